// ---- design/scd_defines.svh ----
// constants of the serial command decoder
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// instruction bytes
`define SCD_OP_RESET 8'hC0
`define SCD_OP_READ 8'h03
`define SCD_OP_WRITE 8'h02
`define SCD_OP_BITMOD 8'h05
`define SCD_OP_RD_STATUS 8'hA0
`define SCD_OP_RX_STATUS 8'hB0

// high five bits of the instruction families with embedded selects
`define SCD_FAM_RXREAD 5'h12
`define SCD_FAM_TXLOAD 5'h08
`define SCD_FAM_RTS 5'h10

// buffer address layout
`define SCD_TX_BASE 8'h30
`define SCD_RX_BASE 8'h60
`define SCD_BUF_STEP 8'h10
`define SCD_ID_OFS 8'h01
`define SCD_DATA_OFS 8'h06

// whole-byte write mask
`define SCD_MASK_ALL 8'hFF

// serial bits in one byte, less one
`define SCD_LAST_BIT 3'h7

`endif

// ---- design/scd_pkg.sv ----
// types of the serial command decoder
package scd_pkg;

  // byte position within a command
  typedef enum logic [2:0] {
    SCD_S_CMD = 3'b000,
    SCD_S_ADDR = 3'b001,
    SCD_S_MASK = 3'b010,
    SCD_S_BMDATA = 3'b011,
    SCD_S_READ = 3'b100,
    SCD_S_WRITE = 3'b101,
    SCD_S_STAT = 3'b110,
    SCD_S_IGNORE = 3'b111
  } scd_state_t;

  // command that an address byte belongs to
  typedef enum logic [1:0] {
    SCD_OPK_READ = 2'b00,
    SCD_OPK_WRITE = 2'b01,
    SCD_OPK_BITMOD = 2'b10
  } scd_opk_t;

endpackage : scd_pkg

// ---- design/scd_byte_if.sv ----
// byte stream between the serial shifter and the decoder
`timescale 1ns/1ps
interface scd_byte_if;
  logic frame_start;
  logic frame_end;
  logic byte_valid;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;

  // shifter side
  modport shf (
    output frame_start,
    output frame_end,
    output byte_valid,
    output rx_byte,
    input tx_byte
  );

  // decoder side
  modport dec (
    input frame_start,
    input frame_end,
    input byte_valid,
    input rx_byte,
    output tx_byte
  );
endinterface : scd_byte_if

// ---- design/scd_spi_shift.sv ----
// serial shifter: pin sync, edge detect, byte in and byte out
`timescale 1ns/1ps
`include "scd_defines.svh"
module scd_spi_shift (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // byte stream
  scd_byte_if.shf bi
);

  logic sck_s1_reg, sck_s2_reg, sck_d_reg;
  logic cs_s1_reg, cs_s2_reg, cs_d_reg;
  logic si_s1_reg, si_s2_reg;
  logic [2:0] cnt_reg, cnt_next;
  logic [6:0] sh_reg, sh_next;
  logic [7:0] out_reg, out_next;
  logic so_reg, so_next;
  logic oe_reg, oe_next;
  logic bv_reg, bv_next;
  logic [7:0] rxb_reg, rxb_next;
  logic fs_reg, fs_next;
  logic fe_reg, fe_next;
  logic rise, fall, sel;

  //////////////////////////////////////////////////////////////////////
  // two-stage synchronisers, third stage for edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_d_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_d_reg <= 1'b1;
      si_s1_reg <= 1'b0;
      si_s2_reg <= 1'b0;
    end else begin
      sck_s1_reg <= sck;
      sck_s2_reg <= sck_s1_reg;
      sck_d_reg <= sck_s2_reg;
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_d_reg <= cs_s2_reg;
      si_s1_reg <= si;
      si_s2_reg <= si_s1_reg;
    end
  end

  assign rise = sck_s2_reg & ~sck_d_reg;
  assign fall = ~sck_s2_reg & sck_d_reg;
  assign sel = ~cs_s2_reg;

  //////////////////////////////////////////////////////////////////////
  // shift in on rising edge, out on falling edge
  always_comb begin
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    out_next = out_reg;
    so_next = so_reg;
    oe_next = sel;
    bv_next = 1'b0;
    rxb_next = rxb_reg;
    fs_next = cs_d_reg & ~cs_s2_reg;
    fe_next = ~cs_d_reg & cs_s2_reg;
    if (!sel) begin
      cnt_next = 3'h0;
    end else if (rise) begin
      sh_next = {sh_reg[5:0], si_s2_reg};
      cnt_next = cnt_reg + 3'h1;
      if (cnt_reg == `SCD_LAST_BIT) begin
        bv_next = 1'b1;
        rxb_next = {sh_reg, si_s2_reg};
      end
    end else if (fall) begin
      // byte boundary: take a fresh byte from the decoder
      if (cnt_reg == 3'h0) begin
        so_next = bi.tx_byte[7];
        out_next = {bi.tx_byte[6:0], 1'b0};
      end else begin
        so_next = out_reg[7];
        out_next = {out_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 3'h0;
      sh_reg <= 7'h00;
      out_reg <= 8'h00;
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
      bv_reg <= 1'b0;
      rxb_reg <= 8'h00;
      fs_reg <= 1'b0;
      fe_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      out_reg <= out_next;
      so_reg <= so_next;
      oe_reg <= oe_next;
      bv_reg <= bv_next;
      rxb_reg <= rxb_next;
      fs_reg <= fs_next;
      fe_reg <= fe_next;
    end
  end

  assign so = so_reg;
  assign so_oe = oe_reg;
  assign bi.byte_valid = bv_reg;
  assign bi.rx_byte = rxb_reg;
  assign bi.frame_start = fs_reg;
  assign bi.frame_end = fe_reg;

endmodule : scd_spi_shift

// ---- design/scd_cmd_decoder.sv ----
// serial command decoder of a CAN controller
//
// Behaviour
// - bit modify is instruction, address, mask, then data byte
// - bit modify changes only bits whose mask bit is one
// - masked bits take the data bit value, set on one, clear on zero
// - registers without bit modify get mask all ones, a byte write
// - byte 0xC0 resets all registers and enters configuration mode
// - byte 0x03 plus address reads registers from that address
// - 1001_0nm0 points at one of four receive locations and reads
// - receive buffer read clears its receive full flag at chip select high
// - byte 0x02 plus address writes data bytes from that address
// - 0100_0abc points at one of six transmit locations and writes
// - 1000_0nnn requests transmission for each buffer bit set
// - byte 0xA0 returns a quick transmit and receive status byte
// - byte 0xB0 returns filter match and message type byte
// - byte 0x05 is the masked bit modify instruction
// - receive status reports buffer zero in low bits when both full
// - first byte after chip select falls is always an instruction
// - input sampled on rising clock, output driven on falling clock
// - request to send with all select bits zero is ignored
// - read address advances after each byte shifted out
`timescale 1ns/1ps
`include "scd_defines.svh"
module scd_cmd_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // register file access
  output logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_bitmod_ok,
  output logic reg_we,
  output logic [7:0] reg_waddr,
  output logic [7:0] reg_wdata,
  output logic [7:0] reg_wmask,
  // device actions
  output logic soft_reset,
  output logic [2:0] transmit_request_set,
  output logic [1:0] receive_full_flag_clr,
  // quick status sources
  input wire logic [7:0] read_status_in,
  input wire logic [1:0] receive_full_flag,
  input wire logic [4:0] rx_desc_zero,
  input wire logic [4:0] rx_desc_one
);

  scd_byte_if bi ();

  scd_pkg::scd_state_t state_reg, state_next;
  scd_pkg::scd_opk_t op_reg, op_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] tx_reg, tx_next;
  logic fetch_reg, fetch_next;
  logic stat_rx_reg, stat_rx_next;
  logic rxread_reg, rxread_next;
  logic rxbuf_reg, rxbuf_next;
  logic we_reg, we_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic [7:0] wmask_reg, wmask_next;
  logic sreset_reg, sreset_next;
  logic [2:0] rts_reg, rts_next;
  logic [1:0] rxclr_reg, rxclr_next;
  logic [7:0] b;
  logic [7:0] tx_base;
  logic [7:0] rx_stat;
  logic [7:0] read_ofs;

  //////////////////////////////////////////////////////////////////////
  // serial shifter
  scd_spi_shift u_shift (
    .clk(clk),
    .resetn(resetn),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .so(so),
    .so_oe(so_oe),
    .bi(bi.shf)
  );

  assign b = bi.rx_byte;

  // transmit buffer base picked by bits a and b
  always_comb begin
    unique case (b[2:1])
      2'b00: tx_base = `SCD_TX_BASE;
      2'b01: tx_base = `SCD_TX_BASE + `SCD_BUF_STEP;
      default: tx_base = `SCD_TX_BASE + `SCD_BUF_STEP + `SCD_BUF_STEP;
    endcase
  end

  // receive status, buffer zero first
  always_comb begin
    rx_stat = {receive_full_flag, 6'h00};
    if (receive_full_flag[0]) begin
      rx_stat[4:0] = rx_desc_zero;
    end else if (receive_full_flag[1]) begin
      rx_stat[4:0] = rx_desc_one;
    end
  end

  assign read_ofs = b[1] ? `SCD_DATA_OFS : `SCD_ID_OFS;

  //////////////////////////////////////////////////////////////////////
  // command sequencing
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    ptr_next = ptr_reg;
    mask_next = mask_reg;
    tx_next = tx_reg;
    fetch_next = 1'b0;
    stat_rx_next = stat_rx_reg;
    rxread_next = rxread_reg;
    rxbuf_next = rxbuf_reg;
    we_next = 1'b0;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wmask_next = wmask_reg;
    sreset_next = 1'b0;
    rts_next = 3'h0;
    rxclr_next = 2'h0;
    // register data for the next outgoing byte
    if (fetch_reg) begin
      tx_next = reg_rdata;
    end
    if (bi.frame_start) begin
      state_next = scd_pkg::SCD_S_CMD;
      tx_next = 8'h00;
      rxread_next = 1'b0;
    end else if (bi.frame_end) begin
      if (rxread_reg) begin
        rxclr_next = rxbuf_reg ? 2'b10 : 2'b01;
      end
      rxread_next = 1'b0;
      state_next = scd_pkg::SCD_S_CMD;
    end else if (bi.byte_valid) begin
      unique case (state_reg)
        scd_pkg::SCD_S_CMD: begin
          state_next = scd_pkg::SCD_S_IGNORE;
          if (b == `SCD_OP_RESET) begin
            sreset_next = 1'b1;
          end else if (b == `SCD_OP_READ) begin
            op_next = scd_pkg::SCD_OPK_READ;
            state_next = scd_pkg::SCD_S_ADDR;
          end else if (b == `SCD_OP_WRITE) begin
            op_next = scd_pkg::SCD_OPK_WRITE;
            state_next = scd_pkg::SCD_S_ADDR;
          end else if (b == `SCD_OP_BITMOD) begin
            op_next = scd_pkg::SCD_OPK_BITMOD;
            state_next = scd_pkg::SCD_S_ADDR;
          end else if (b == `SCD_OP_RD_STATUS) begin
            stat_rx_next = 1'b0;
            tx_next = read_status_in;
            state_next = scd_pkg::SCD_S_STAT;
          end else if (b == `SCD_OP_RX_STATUS) begin
            stat_rx_next = 1'b1;
            tx_next = rx_stat;
            state_next = scd_pkg::SCD_S_STAT;
          end else if (b[7:3] == `SCD_FAM_RXREAD && !b[0]) begin
            // n picks the buffer, m picks id or data
            ptr_next = `SCD_RX_BASE + (b[2] ? `SCD_BUF_STEP : 8'h00) + read_ofs;
            fetch_next = 1'b1;
            rxread_next = 1'b1;
            rxbuf_next = b[2];
            state_next = scd_pkg::SCD_S_READ;
          end else if (b[7:3] == `SCD_FAM_TXLOAD && b[2:1] != 2'b11) begin
            ptr_next = tx_base + (b[0] ? `SCD_DATA_OFS : `SCD_ID_OFS);
            state_next = scd_pkg::SCD_S_WRITE;
          end else if (b[7:3] == `SCD_FAM_RTS) begin
            rts_next = b[2:0];
          end
        end
        scd_pkg::SCD_S_ADDR: begin
          ptr_next = b;
          unique case (op_reg)
            scd_pkg::SCD_OPK_READ: begin
              fetch_next = 1'b1;
              state_next = scd_pkg::SCD_S_READ;
            end
            scd_pkg::SCD_OPK_WRITE: state_next = scd_pkg::SCD_S_WRITE;
            default: state_next = scd_pkg::SCD_S_MASK;
          endcase
        end
        scd_pkg::SCD_S_MASK: begin
          mask_next = b;
          state_next = scd_pkg::SCD_S_BMDATA;
        end
        scd_pkg::SCD_S_BMDATA: begin
          we_next = 1'b1;
          waddr_next = ptr_reg;
          wdata_next = b;
          wmask_next = reg_bitmod_ok ? mask_reg : `SCD_MASK_ALL;
          state_next = scd_pkg::SCD_S_IGNORE;
        end
        scd_pkg::SCD_S_WRITE: begin
          we_next = 1'b1;
          waddr_next = ptr_reg;
          wdata_next = b;
          wmask_next = `SCD_MASK_ALL;
          ptr_next = ptr_reg + 8'h01;
        end
        scd_pkg::SCD_S_READ: begin
          ptr_next = ptr_reg + 8'h01;
          fetch_next = 1'b1;
        end
        scd_pkg::SCD_S_STAT: begin
          tx_next = stat_rx_reg ? rx_stat : read_status_in;
        end
        scd_pkg::SCD_S_IGNORE: begin
          state_next = scd_pkg::SCD_S_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= scd_pkg::SCD_S_IGNORE;
      op_reg <= scd_pkg::SCD_OPK_READ;
      ptr_reg <= 8'h00;
      mask_reg <= 8'h00;
      tx_reg <= 8'h00;
      fetch_reg <= 1'b0;
      stat_rx_reg <= 1'b0;
      rxread_reg <= 1'b0;
      rxbuf_reg <= 1'b0;
      we_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wmask_reg <= 8'h00;
      sreset_reg <= 1'b0;
      rts_reg <= 3'h0;
      rxclr_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      ptr_reg <= ptr_next;
      mask_reg <= mask_next;
      tx_reg <= tx_next;
      fetch_reg <= fetch_next;
      stat_rx_reg <= stat_rx_next;
      rxread_reg <= rxread_next;
      rxbuf_reg <= rxbuf_next;
      we_reg <= we_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wmask_reg <= wmask_next;
      sreset_reg <= sreset_next;
      rts_reg <= rts_next;
      rxclr_reg <= rxclr_next;
    end
  end

  // outputs straight from flops
  assign bi.tx_byte = tx_reg;
  assign reg_addr = ptr_reg;
  assign reg_we = we_reg;
  assign reg_waddr = waddr_reg;
  assign reg_wdata = wdata_reg;
  assign reg_wmask = wmask_reg;
  assign soft_reset = sreset_reg;
  assign transmit_request_set = rts_reg;
  assign receive_full_flag_clr = rxclr_reg;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic cmd_ok;
  logic [2:0] rx_low3;
  assign cmd_ok = bi.byte_valid && state_reg == scd_pkg::SCD_S_CMD;
  assign rx_low3 = bi.rx_byte[2:0];

  a_reset_cmd: assert property (cmd_ok && bi.rx_byte == `SCD_OP_RESET |=> soft_reset ##1 !soft_reset) else $error("reset instruction not decoded");
  a_rts_bits: assert property (cmd_ok && bi.rx_byte[7:3] == `SCD_FAM_RTS |=> transmit_request_set == $past(rx_low3)) else $error("request to send bits wrong");
  a_rts_zero: assert property (cmd_ok && bi.rx_byte == 8'h80 |=> transmit_request_set == 3'h0) else $error("empty request to send acted");
  a_bm_masked: assert property (bi.byte_valid && state_reg == scd_pkg::SCD_S_BMDATA && reg_bitmod_ok |=> reg_we && reg_wmask == $past(mask_reg)) else $error("bit modify mask wrong");
  a_bm_full: assert property (bi.byte_valid && state_reg == scd_pkg::SCD_S_BMDATA && !reg_bitmod_ok |=> reg_we && reg_wmask == `SCD_MASK_ALL) else $error("mask not forced full");
  a_bm_data: assert property (bi.byte_valid && state_reg == scd_pkg::SCD_S_BMDATA |=> reg_wdata == $past(bi.rx_byte) && reg_waddr == $past(reg_addr)) else $error("bit modify data wrong");
  a_write_addr: assert property (bi.byte_valid && state_reg == scd_pkg::SCD_S_WRITE |=> reg_we && reg_waddr == $past(reg_addr) && reg_addr == 8'($past(reg_addr) + 8'h01)) else $error("sequential write wrong");
  a_read_inc: assert property (bi.byte_valid && state_reg == scd_pkg::SCD_S_READ |=> reg_addr == 8'($past(reg_addr) + 8'h01) ##1 bi.tx_byte == $past(reg_rdata)) else $error("read pointer not advanced");
  a_rx_clear: assert property (bi.frame_end && rxread_reg |=> receive_full_flag_clr != 2'h0 ##1 receive_full_flag_clr == 2'h0) else $error("receive flag not cleared");
  a_ignore_quiet: assert property (state_reg == scd_pkg::SCD_S_IGNORE && !bi.frame_start |=> !reg_we) else $error("write while ignoring");
  a_frame_cmd: assert property (bi.frame_start |=> state_reg == scd_pkg::SCD_S_CMD) else $error("frame did not start at instruction");

  c_read: cover property (bi.byte_valid && state_reg == scd_pkg::SCD_S_READ);
  c_write: cover property (reg_we && reg_wmask == `SCD_MASK_ALL);
  c_bitmod: cover property (bi.byte_valid && state_reg == scd_pkg::SCD_S_BMDATA && reg_bitmod_ok);
  c_rxclr: cover property (receive_full_flag_clr != 2'h0);

endmodule : scd_cmd_decoder

// ---- verification/scd_host_model.sv ----
// host side model: serial master in mode 0,0
`timescale 1ns/1ps
module scd_host_model (
  // serial pins
  input wire logic so,
  output logic sck,
  output logic cs_n,
  output logic si
);
  realtime half_period = 62.5;
  realtime byte_gap = 0.0;

  // idle lines at time zero, clock stands low outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // select the device before any instruction bit
  task automatic frame_begin();
    cs_n = 1'b0;
    #(half_period);
  endtask : frame_begin

  // one byte each way, msb first; bytes go in the order given
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #(half_period);
      sck = 1'b1;
      rx[i] = so;
      #(half_period);
      sck = 1'b0;
    end
    #(byte_gap);
  endtask : xfer

  // deselect; every new command needs a fresh select
  task automatic frame_end();
    #(half_period);
    cs_n = 1'b1;
    si = ~si; // released line shows no stale level
    #(4 * half_period);
  endtask : frame_end
endmodule : scd_host_model

// ---- verification/spi_command_decoder_test.sv ----
// self-checking bench of the serial command decoder
`timescale 1ns/1ps
module spi_command_decoder_test;
  logic clk;
  logic resetn;
  logic sck, cs_n, si, so, so_oe;
  logic [7:0] reg_addr, reg_rdata, reg_waddr, reg_wdata, reg_wmask;
  logic reg_bitmod_ok, reg_we, soft_reset;
  logic [2:0] transmit_request_set, rts_seen;
  logic [1:0] receive_full_flag_clr, receive_full_flag, clr_seen;
  logic [7:0] read_status_in, last_mask;
  logic [4:0] rx_desc_zero, rx_desc_one;
  logic [7:0] reg_mem [256];
  logic rst_seen;
  int we_count, err_total, compares, cycles;

  ////////////////////////////////////////
  scd_cmd_decoder scd_cmd_decoder_inst (
    .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_bitmod_ok(reg_bitmod_ok),
    .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .reg_wmask(reg_wmask),
    .soft_reset(soft_reset), .transmit_request_set(transmit_request_set),
    .receive_full_flag_clr(receive_full_flag_clr), .read_status_in(read_status_in),
    .receive_full_flag(receive_full_flag), .rx_desc_zero(rx_desc_zero),
    .rx_desc_one(rx_desc_one)
  );
  scd_host_model host_inst (.so(so), .sck(sck), .cs_n(cs_n), .si(si));

  // register file: upper half refuses bit modify
  assign reg_rdata = reg_mem[reg_addr];
  assign reg_bitmod_ok = ~reg_addr[7];

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // apply writes and collect action pulses
  always @(posedge clk) begin
    if (reg_we) begin
      reg_mem[reg_waddr] <= (reg_mem[reg_waddr] & ~reg_wmask) | (reg_wdata & reg_wmask);
      last_mask <= reg_wmask;
      we_count <= we_count + 1;
    end
    if (soft_reset) rst_seen <= 1'b1;
    rts_seen <= rts_seen | transmit_request_set;
    clr_seen <= clr_seen | receive_full_flag_clr;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // whole frame: clear monitors, send bytes, collect replies
  task automatic run_frame(input logic [7:0] txq[$], output logic [7:0] rxq[$]);
    logic [7:0] r;
    @(posedge clk);
    #1;
    rst_seen = 1'b0;
    rts_seen = 3'h0;
    clr_seen = 2'h0;
    we_count = 0;
    rxq = {};
    host_inst.frame_begin();
    check({7'h0, so_oe}, 8'h01);
    foreach (txq[i]) begin
      host_inst.xfer(txq[i], r);
      rxq.push_back(r);
    end
    host_inst.frame_end();
    check({7'h0, so_oe}, 8'h00);
    // settle past the edge so callers change inputs off the sampling edge
    repeat (8) @(posedge clk);
    #1;
  endtask : run_frame

  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////
  // burst write with a slow host, then burst read back
  task automatic t_write_read();
    logic [7:0] rx[$];
    host_inst.byte_gap = 500.0;
    run_frame('{8'h02, 8'h2A, 8'h11, 8'h22, 8'h33}, rx);
    host_inst.byte_gap = 0.0;
    check(reg_mem[8'h2A], 8'h11);
    check(reg_mem[8'h2C], 8'h33);
    run_frame('{8'h03, 8'h2A, 8'h00, 8'h00, 8'h00}, rx);
    check(rx[2], 8'h11);
    check(rx[3], 8'h22);
    check(rx[4], 8'h33);
    check({6'h0, clr_seen}, 8'h00);
  endtask : t_write_read

  // masked update on a modifiable and a plain register
  task automatic t_bitmod();
    logic [7:0] rx[$];
    reg_mem[8'h20] = 8'hF0;
    reg_mem[8'h90] = 8'hF0;
    run_frame('{8'h05, 8'h20, 8'h3C, 8'hA5, 8'hFF}, rx);
    check(reg_mem[8'h20], 8'hE4);
    check(last_mask, 8'h3C);
    check(8'(we_count), 8'h01);
    run_frame('{8'h05, 8'h90, 8'h0F, 8'h5A}, rx);
    check(reg_mem[8'h90], 8'h5A);
  endtask : t_bitmod

  // all four quick receive reads and their flag clears
  task automatic t_rx_read();
    logic [7:0] rx[$];
    logic [7:0] a;
    for (int k = 0; k < 4; k++) begin
      a = 8'h60 + (k[1] ? 8'h10 : 8'h00) + (k[0] ? 8'h06 : 8'h01);
      reg_mem[a] = 8'h80 | 8'(k);
      run_frame('{8'h90 | 8'(k << 1), 8'h00}, rx);
      check(rx[1], 8'h80 | 8'(k));
      check({6'h0, clr_seen}, k[1] ? 8'h02 : 8'h01);
    end
  endtask : t_rx_read

  // all six quick transmit loads
  task automatic t_tx_load();
    logic [7:0] rx[$];
    logic [7:0] a;
    for (int k = 0; k < 6; k++) begin
      a = 8'h30 + 8'((k >> 1) * 16) + (k[0] ? 8'h06 : 8'h01);
      run_frame('{8'h40 | 8'(k), 8'h70 + 8'(k)}, rx);
      check(reg_mem[a], 8'h70 + 8'(k));
    end
  endtask : t_tx_load

  // every transmit select pattern, none included
  task automatic t_rts();
    logic [7:0] rx[$];
    for (int k = 0; k < 8; k++) begin
      run_frame('{8'h80 | 8'(k)}, rx);
      check({5'h0, rts_seen}, 8'(k));
    end
  endtask : t_rts

  // quick status polls, repeated reply and buffer priority
  task automatic t_status();
    logic [7:0] rx[$];
    read_status_in = 8'h5C;
    run_frame('{8'hA0, 8'h00, 8'h00}, rx);
    check(rx[1], 8'h5C);
    check(rx[2], 8'h5C);
    receive_full_flag = 2'b11;
    run_frame('{8'hB0, 8'h00}, rx);
    check(rx[1], 8'hCA);
    receive_full_flag = 2'b10;
    run_frame('{8'hB0, 8'h00}, rx);
    check(rx[1], 8'h95);
  endtask : t_status

  // reset command, unknown command, instruction only at frame start
  task automatic t_misc();
    logic [7:0] rx[$];
    run_frame('{8'hC0, 8'h02, 8'h40, 8'h01}, rx);
    check({7'h0, rst_seen}, 8'h01);
    check(8'(we_count), 8'h00);
    reg_mem[8'h41] = 8'h77;
    run_frame('{8'hFF, 8'h02, 8'h41, 8'h00}, rx);
    check(8'(we_count), 8'h00);
    check(reg_mem[8'h41], 8'h77);
    run_frame('{8'h46, 8'h99}, rx);
    check(8'(we_count), 8'h00);
    run_frame('{8'h02, 8'h12, 8'hC0}, rx);
    check(reg_mem[8'h12], 8'hC0);
    check({7'h0, rst_seen}, 8'h00);
  endtask : t_misc

  ////////////////////////////////////////
  // reset, then scenarios
  initial begin
    err_total = 0;
    compares = 0;
    cycles = 0;
    we_count = 0;
    rst_seen = 1'b0;
    rts_seen = 3'h0;
    clr_seen = 2'h0;
    last_mask = 8'h00;
    read_status_in = 8'h00;
    receive_full_flag = 2'b00;
    rx_desc_zero = 5'h0A;
    rx_desc_one = 5'h15;
    foreach (reg_mem[i]) reg_mem[i] = 8'h00;
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (5) @(posedge clk);
    t_write_read();
    t_bitmod();
    t_rx_read();
    t_tx_load();
    t_rts();
    t_status();
    t_misc();
    tally_and_finish();
  end
endmodule : spi_command_decoder_test
